// >>> rtl/bst_defs.svh
// constants of the boundary-scan test port: op codes, chain layout, reset values
`ifndef BST_DEFS_SVH
`define BST_DEFS_SVH

// ----------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------
`define BST_IR_W        5
`define BST_OP_EXTEST   5'h00
`define BST_OP_SAMPLE   5'h01
`define BST_OP_CLAMP    5'h04
`define BST_OP_HIGHZ    5'h05
`define BST_OP_BYPASS   5'h1F
`define BST_IR_CAPTURE  5'h01

// ----------------------------------------------------------------
// boundary-scan chain
// ----------------------------------------------------------------
`define BST_CHAIN_LEN   20
`define BST_PAD_W       18
`define BST_CELL_STRAP  13
`define BST_CELL_CTRL   19
`define BST_CHAIN_RESET 20'h00000
`define BST_BYPASS_CAP  1'h0

`endif

// >>> rtl/bst_pkg.sv
// types and chain mapping functions of the boundary-scan test port
package bst_pkg;
	`include "bst_defs.svh"

	// ----------------------------------------------------------------
	// test access port controller states, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [15:0] {
		TAP_RESET  = 16'h0001,
		TAP_IDLE   = 16'h0002,
		TAP_SEL_DR = 16'h0004,
		TAP_CAP_DR = 16'h0008,
		TAP_SH_DR  = 16'h0010,
		TAP_EX1_DR = 16'h0020,
		TAP_PA_DR  = 16'h0040,
		TAP_EX2_DR = 16'h0080,
		TAP_UPD_DR = 16'h0100,
		TAP_SEL_IR = 16'h0200,
		TAP_CAP_IR = 16'h0400,
		TAP_SH_IR  = 16'h0800,
		TAP_EX1_IR = 16'h1000,
		TAP_PA_IR  = 16'h2000,
		TAP_EX2_IR = 16'h4000,
		TAP_UPD_IR = 16'h8000
	} bst_tap_t;

	// ----------------------------------------------------------------
	// secondary-side terminals covered by the chain
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        secondaryFastClockEnable;
		logic        secondaryCmdByteEnable0;
		logic [15:0] secondaryAddrData;
	} bst_pads_t;

	// test clock domain state
	typedef struct packed {
		bst_tap_t                  tap;
		logic [`BST_IR_W-1:0]      ir;
		logic [`BST_IR_W-1:0]      irShift;
		logic [`BST_CHAIN_LEN-1:0] bsrShift;
		logic [`BST_CHAIN_LEN-1:0] bsrUpd;
		logic                      bypassBit;
		bst_pads_t                 padS1;
		bst_pads_t                 padS2;
		logic                      strapS1;
		logic                      strapS2;
		logic                      pushTgl;
	} bst_tck_state_t;

	// falling-edge output stage of the test data output
	typedef struct packed {
		logic tdo;
		logic tdoOe;
	} bst_tdo_state_t;

	// system clock domain state
	typedef struct packed {
		logic                      tglS1;
		logic                      tglS2;
		logic                      tglSeen;
		logic                      trstS1;
		logic                      trstS2;
		logic [`BST_IR_W-1:0]      irHeld;
		logic [`BST_CHAIN_LEN-1:0] updHeld;
		bst_pads_t                 padS1;
		bst_pads_t                 padS2;
		logic                      strapS1;
		logic                      strapS2;
		bst_pads_t                 padOut;
		bst_pads_t                 padOe;
		bst_pads_t                 coreIn;
		logic                      coreStrap;
	} bst_sys_state_t;

	// ----------------------------------------------------------------
	// chain order: cell 0 is address/data bit 0, cell 19 the control cell
	// ----------------------------------------------------------------
	function automatic logic [`BST_CHAIN_LEN-1:0] bst_cells_from_pads(
		input bst_pads_t p,
		input logic      strap,
		input logic      ctrl);
		return {ctrl, p.secondaryAddrData[15:11], strap, p.secondaryAddrData[10],
			p.secondaryFastClockEnable, p.secondaryAddrData[9:8],
			p.secondaryCmdByteEnable0, p.secondaryAddrData[7:0]};
	endfunction

	function automatic bst_pads_t bst_pads_from_cells(input logic [`BST_CHAIN_LEN-1:0] c);
		bst_pads_t p;
		p.secondaryAddrData        = {c[18:14], c[12], c[10:9], c[7:0]};
		p.secondaryCmdByteEnable0  = c[8];
		p.secondaryFastClockEnable = c[11];
		return p;
	endfunction

	// standard controller walk
	function automatic bst_tap_t bst_next_tap(input bst_tap_t s, input logic tms);
		case (s)
			TAP_RESET:  return tms ? TAP_RESET  : TAP_IDLE;
			TAP_IDLE:   return tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: return tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: return tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR:  return tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: return tms ? TAP_UPD_DR : TAP_PA_DR;
			TAP_PA_DR:  return tms ? TAP_EX2_DR : TAP_PA_DR;
			TAP_EX2_DR: return tms ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: return tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: return tms ? TAP_RESET  : TAP_CAP_IR;
			TAP_CAP_IR: return tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR:  return tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: return tms ? TAP_UPD_IR : TAP_PA_IR;
			TAP_PA_IR:  return tms ? TAP_EX2_IR : TAP_PA_IR;
			TAP_EX2_IR: return tms ? TAP_UPD_IR : TAP_SH_IR;
			TAP_UPD_IR: return tms ? TAP_SEL_DR : TAP_IDLE;
			default:    return TAP_RESET;
		endcase
	endfunction
endpackage

// >>> rtl/bst_test_port.sv
// boundary-scan test port: controller, instruction, bypass and boundary registers
//
// Notes on behaviour
// - controller, instruction, bypass and boundary registers follow the boundary-scan standard
// - five wires: test clock, mode select, data in, data out, test reset
// - code 00000 external test drives every terminal from the boundary register
// - five-bit codes; 00001 samples terminals into the chain, normal operation untouched
// - code 00100 clamps terminals from the chain, shifts through bypass
// - code 00101 releases all terminals to high impedance, data out still drives
// - code 11111 puts the one-bit bypass register between data in and out
// - chain starts with address/data bit 0; cell 13 is input-only mode strap
// - cell 19 is the control cell enabling the drivers of cells 0 to 18 other than strap cell 13
`timescale 1ns/1ps
`default_nettype none
`include "bst_defs.svh"

module bst_test_port (
	// test access port
	input  wire logic              testClk,
	input  wire logic              testResetN,
	input  wire logic              testModeSel,
	input  wire logic              testDataIn,
	output logic                   testDataOut,
	output logic                   testDataOutOe,
	// system clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// core side of the terminals
	input  wire bst_pkg::bst_pads_t coreOut,
	input  wire bst_pkg::bst_pads_t coreOe,
	output bst_pkg::bst_pads_t     coreIn,
	output logic                   coreStrap,
	// terminal side
	input  wire bst_pkg::bst_pads_t padIn,
	input  wire logic              modeStrapZero,
	output bst_pkg::bst_pads_t     padOut,
	output bst_pkg::bst_pads_t     padOe
);
	import bst_pkg::*;

	localparam bst_tck_state_t TCK_RST = '{tap: TAP_RESET, ir: `BST_OP_BYPASS,
		irShift: `BST_IR_CAPTURE, bsrShift: `BST_CHAIN_RESET, bsrUpd: `BST_CHAIN_RESET,
		default: '0};
	localparam bst_sys_state_t SYS_RST = '{irHeld: `BST_OP_BYPASS,
		updHeld: `BST_CHAIN_RESET, default: '0};

	bst_tck_state_t            t;
	bst_tck_state_t            next_t;
	bst_tdo_state_t            d;
	bst_tdo_state_t            next_d;
	bst_sys_state_t            s;
	bst_sys_state_t            next_s;
	logic                      selBsr;
	logic [`BST_CHAIN_LEN-1:0] cellsIn;
	bst_pads_t                 chainPads;

	// ----------------------------------------------------------------
	// test clock domain
	// ----------------------------------------------------------------

	// only external test and sample route the boundary chain; any other code,
	// the reserved private ones included, falls back to bypass
	assign selBsr = (t.ir == `BST_OP_EXTEST) || (t.ir == `BST_OP_SAMPLE);

	// capture image: synchronised terminals, the strap, and the live control cell
	assign cellsIn = bst_cells_from_pads(t.padS2, t.strapS2, t.bsrUpd[`BST_CELL_CTRL]);

	// controller and shift registers
	always_comb begin
		next_t         = t;
		next_t.tap     = bst_next_tap(t.tap, testModeSel);
		next_t.padS1   = padIn;
		next_t.padS2   = t.padS1;
		next_t.strapS1 = modeStrapZero;
		next_t.strapS2 = t.strapS1;
		case (t.tap)
			TAP_RESET: begin
				next_t.ir = `BST_OP_BYPASS;
				// tell the system side when a mode-select reset drops an active mode
				if (t.ir != `BST_OP_BYPASS) begin
					next_t.pushTgl = ~t.pushTgl;
				end
			end
			TAP_CAP_IR: begin
				next_t.irShift = `BST_IR_CAPTURE;
			end
			TAP_SH_IR: begin
				next_t.irShift = {testDataIn, t.irShift[`BST_IR_W-1:1]};
			end
			TAP_UPD_IR: begin
				next_t.ir      = t.irShift;
				next_t.pushTgl = ~t.pushTgl;
			end
			TAP_CAP_DR: begin
				if (selBsr) begin
					next_t.bsrShift = cellsIn;
				end else begin
					next_t.bypassBit = `BST_BYPASS_CAP;
				end
			end
			TAP_SH_DR: begin
				if (selBsr) begin
					next_t.bsrShift = {testDataIn, t.bsrShift[`BST_CHAIN_LEN-1:1]};
				end else begin
					next_t.bypassBit = testDataIn;
				end
			end
			TAP_UPD_DR: begin
				// bypass updates leave the held chain image alone
				if (selBsr) begin
					next_t.bsrUpd  = t.bsrShift;
					next_t.pushTgl = ~t.pushTgl;
				end
			end
			default: begin
			end
		endcase
	end

	// test reset is the only reset of this domain
	always_ff @(posedge testClk or negedge testResetN) begin
		if (!testResetN) begin
			t <= TCK_RST;
		end else begin
			t <= next_t;
		end
	end

	// data out changes on the falling edge and drives only while shifting
	always_comb begin
		next_d       = d;
		next_d.tdoOe = (t.tap == TAP_SH_DR) || (t.tap == TAP_SH_IR);
		if (t.tap == TAP_SH_IR) begin
			next_d.tdo = t.irShift[0];
		end else if (selBsr) begin
			next_d.tdo = t.bsrShift[0];
		end else begin
			next_d.tdo = t.bypassBit;
		end
	end

	always_ff @(negedge testClk or negedge testResetN) begin
		if (!testResetN) begin
			d <= '0;
		end else begin
			d <= next_d;
		end
	end

	assign testDataOut   = d.tdo;
	assign testDataOutOe = d.tdoOe;

	// ----------------------------------------------------------------
	// system clock domain
	// ----------------------------------------------------------------

	assign chainPads = bst_pads_from_cells(s.updHeld);

	// the held instruction and chain image only change on an update or a mode-select reset, and the next
	// change is at least three test clocks away, so the words are stable when the
	// synchronised toggle edge lets this side take them
	always_comb begin
		next_s         = s;
		next_s.tglS1   = t.pushTgl;
		next_s.tglS2   = s.tglS1;
		next_s.tglSeen = s.tglS2;
		next_s.trstS1  = testResetN;
		next_s.trstS2  = s.trstS1;
		next_s.padS1   = padIn;
		next_s.padS2   = s.padS1;
		next_s.strapS1 = modeStrapZero;
		next_s.strapS2 = s.strapS1;
		if (!s.trstS2) begin
			next_s.irHeld = `BST_OP_BYPASS;
		end else if (s.tglS2 != s.tglSeen) begin
			next_s.irHeld  = t.ir;
			next_s.updHeld = t.bsrUpd;
		end
		// the core always sees the terminals, whatever the test mode
		next_s.coreIn    = s.padS2;
		next_s.coreStrap = s.strapS2;
		case (s.irHeld)
			`BST_OP_EXTEST, `BST_OP_CLAMP: begin
				next_s.padOut = chainPads;
				next_s.padOe  = {`BST_PAD_W{s.updHeld[`BST_CELL_CTRL]}};
			end
			`BST_OP_HIGHZ: begin
				next_s.padOut = '0;
				next_s.padOe  = '0;
			end
			default: begin
				next_s.padOut = coreOut;
				next_s.padOe  = coreOe;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= SYS_RST;
		end else begin
			s <= next_s;
		end
	end

	assign coreIn    = s.coreIn;
	assign coreStrap = s.coreStrap;
	assign padOut    = s.padOut;
	assign padOe     = s.padOe;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------

	sequence tmsHighFive;
		testModeSel [*5];
	endsequence

	sequence shiftInBsr;
		(t.tap == TAP_SH_DR) && selBsr;
	endsequence

	tlr_after_five_a: assert property (@(posedge testClk) disable iff (!testResetN)
		tmsHighFive |=> (t.tap == TAP_RESET) ##1 (t.ir == `BST_OP_BYPASS))
		else $error("five high mode-select clocks did not reach bypass");

	ir_capture_a: assert property (@(posedge testClk) disable iff (!testResetN)
		(t.tap == TAP_CAP_IR) |=> (t.irShift == `BST_IR_CAPTURE))
		else $error("instruction capture pattern wrong");

	ir_update_a: assert property (@(posedge testClk) disable iff (!testResetN)
		(t.tap == TAP_UPD_IR) |=> (t.ir == $past(t.irShift)) && (t.pushTgl != $past(t.pushTgl)))
		else $error("instruction update lost");

	bypass_path_a: assert property (@(posedge testClk) disable iff (!testResetN)
		(t.tap == TAP_SH_DR) && !selBsr |=> (t.bypassBit == $past(testDataIn)))
		else $error("bypass bit did not take data in");

	sample_capture_a: assert property (@(posedge testClk) disable iff (!testResetN)
		(t.tap == TAP_CAP_DR) && (t.ir == `BST_OP_SAMPLE) |=> (t.bsrShift == $past(cellsIn)))
		else $error("sample did not capture terminals");

	chain_shift_a: assert property (@(posedge testClk) disable iff (!testResetN)
		shiftInBsr |=> (t.bsrShift[`BST_CHAIN_LEN-1] == $past(testDataIn))
			&& (t.bsrShift[`BST_CHAIN_LEN-2:0] == $past(t.bsrShift[`BST_CHAIN_LEN-1:1])))
		else $error("boundary chain shift order wrong");

	tdo_enable_a: assert property (@(negedge testClk) disable iff (!testResetN)
		((t.tap == TAP_SH_DR) || (t.tap == TAP_SH_IR)) |=> testDataOutOe)
		else $error("data out not driven while shifting");

	extest_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s.irHeld == `BST_OP_EXTEST) |=> (padOut == $past(chainPads)))
		else $error("external test not driving from chain");

	clamp_ctrl_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s.irHeld == `BST_OP_CLAMP) |=>
			(padOe == {`BST_PAD_W{$past(s.updHeld[`BST_CELL_CTRL])}}))
		else $error("clamp enables do not follow control cell");

	highz_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s.irHeld == `BST_OP_HIGHZ) |=> (padOe == '0))
		else $error("terminals not released in high impedance mode");

	normal_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s.irHeld == `BST_OP_BYPASS) |=> (padOut == $past(coreOut)) && (padOe == $past(coreOe)))
		else $error("bypass disturbed normal terminal drive");

	// sample shares the normal path, so a broken decode shows up as a disturbed terminal
	sample_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s.irHeld == `BST_OP_SAMPLE) |=>
			(padOut == $past(coreOut)) && (padOe == $past(coreOe)))
		else $error("sample disturbed normal terminal drive");

	highz_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s.irHeld == `BST_OP_HIGHZ) |=> (padOut == '0))
		else $error("terminal values not parked in high impedance mode");

	trst_bypass_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!s.trstS2 |=> (s.irHeld == `BST_OP_BYPASS))
		else $error("test reset did not force bypass on the system side");

	cross_take_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s.trstS2 && (s.tglS2 != s.tglSeen) |=> (s.updHeld == $past(t.bsrUpd)) && (s.irHeld == $past(t.ir)))
		else $error("held words not taken across the clock boundary");

	tdo_release_a: assert property (@(negedge testClk) disable iff (!testResetN)
		!((t.tap == TAP_SH_DR) || (t.tap == TAP_SH_IR)) |=> !testDataOutOe)
		else $error("data out driven outside a shift state");

	ir_first_bit_a: assert property (@(negedge testClk) disable iff (!testResetN)
		(t.tap == TAP_SH_IR) |=> (testDataOut == $past(t.irShift[0])))
		else $error("instruction bit not presented on data out");

	chain_update_a: assert property (@(posedge testClk) disable iff (!testResetN)
		(t.tap == TAP_UPD_DR) && selBsr |=> (t.bsrUpd == $past(t.bsrShift)))
		else $error("chain image not updated");

	bypass_update_a: assert property (@(posedge testClk) disable iff (!testResetN)
		(t.tap == TAP_UPD_DR) && !selBsr |=> $stable(t.bsrUpd))
		else $error("bypass update disturbed the held chain image");

endmodule
`default_nettype wire

// >>> testbench/bst_jtag_host.sv
// test controller model that drives the five-wire test access port
`timescale 1ns/1ps
`default_nettype none

module bst_jtag_host (
	// test access port, controller side
	output logic      testClk,
	output logic      testResetN,
	output logic      testModeSel,
	output logic      testDataIn,
	input  wire logic testDataOut,
	input  wire logic testDataOutOe
);
	logic lastOe;

	// the test clock stands still low between scans
	initial begin
		testClk = 1'b0;
		testResetN = 1'b0;
		testModeSel = 1'b1;
		testDataIn = 1'b1;
		lastOe = 1'b0;
	end

	task automatic set_trst(input logic v);
		testResetN = v;
	endtask

	// one 48 ns clock; data out is read at the rising edge, a released line reads as pulled up
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		testModeSel = tms;
		testDataIn = tdi;
		#12;
		testClk = 1'b1;
		tdo = testDataOutOe ? testDataOut : 1'b1;
		lastOe = testDataOutOe;
		#24;
		testClk = 1'b0;
		testDataIn = ~tdi; // stale data is not left on the line
		#12;
	endtask

	// five clocks with mode select high, then to idle
	task automatic go_reset();
		logic t;
		repeat (5) step(1'b1, 1'b0, t);
		step(1'b0, 1'b0, t);
	endtask

	// idle clocks let terminal samples settle before capture; ends back in idle
	task automatic scan(input logic ir, input int n, input logic [19:0] din,
		output logic [19:0] dout, output logic oeAll);
		logic t;
		int   i;
		dout = 20'hFFFFF;
		oeAll = 1'b1;
		for (i = 0; i < 4; i++) step(1'b0, 1'b0, t);
		step(1'b1, 1'b0, t);
		if (ir) step(1'b1, 1'b0, t);
		step(1'b0, 1'b0, t);
		step(1'b0, 1'b0, t);
		for (i = 0; i < n; i++) begin
			step(i == n - 1, din[i], dout[i]);
			oeAll &= lastOe;
		end
		step(1'b1, 1'b0, t);
		step(1'b0, 1'b0, t);
	endtask
endmodule
`default_nettype wire

// >>> testbench/tb_bst_test_port.sv
// self-checking bench of the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
`include "bst_defs.svh"
`define TB_CHK(what, exp, got) \
	begin \
		checks_done++; \
		if ((got) !== (exp)) begin \
			fail_count++; \
			$display("ERROR %s expected %h seen %h", what, exp, got); \
		end \
	end

module tb_bst_test_port;
	import bst_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst_n;
	logic        testClk, testResetN, testModeSel, testDataIn, testDataOut, testDataOutOe;
	bst_pads_t   coreOut, coreOe, coreIn, padIn, padOut, padOe, extPads;
	logic        modeStrapZero, coreStrap, oeAll;
	logic [19:0] dout;
	int          fail_count = 0;
	int          checks_done = 0;
	localparam bst_pads_t IMG = 18'h3C3A5;

	always #25 sys_clk = ~sys_clk;
	// terminal level: our driver where enabled, otherwise the board's value
	assign padIn = bst_pads_t'((padOut & padOe) | (extPads & ~padOe));

	bst_jtag_host u_bst_jtag_host (.testClk(testClk), .testResetN(testResetN),
		.testModeSel(testModeSel), .testDataIn(testDataIn), .testDataOut(testDataOut),
		.testDataOutOe(testDataOutOe));
	bst_test_port u_bst_test_port (.testClk(testClk), .testResetN(testResetN),
		.testModeSel(testModeSel), .testDataIn(testDataIn), .testDataOut(testDataOut),
		.testDataOutOe(testDataOutOe), .sys_clk(sys_clk), .rst_n(rst_n), .coreOut(coreOut),
		.coreOe(coreOe), .coreIn(coreIn), .coreStrap(coreStrap), .padIn(padIn),
		.modeStrapZero(modeStrapZero), .padOut(padOut), .padOe(padOe));

	// chain image of a terminal set, cell 0 in bit 0
	function automatic logic [19:0] cells(input bst_pads_t p, input logic s, input logic c);
		return {c, p.secondaryAddrData[15:11], s, p.secondaryAddrData[10],
			p.secondaryFastClockEnable, p.secondaryAddrData[9:8],
			p.secondaryCmdByteEnable0, p.secondaryAddrData[7:0]};
	endfunction

	// crossing takes a few system clocks; ends on a falling edge
	task automatic settle();
		repeat (10) @(negedge sys_clk);
	endtask

	task automatic load(input logic [4:0] code);
		u_bst_jtag_host.scan(1'b1, 5, {15'h0, code}, dout, oeAll);
		settle();
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk_normal(input string what);
		`TB_CHK(what, coreOut, padOut)
		`TB_CHK(what, coreOe, padOe)
		`TB_CHK(what, padIn, coreIn)
	endtask

	task automatic t_reset();
		u_bst_jtag_host.scan(1'b1, 5, 20'h1F, dout, oeAll);
		`TB_CHK("ir capture", 5'h01, dout[4:0])
		u_bst_jtag_host.scan(1'b0, 8, 20'hA5, dout, oeAll);
		`TB_CHK("bypass path", 8'h4A, dout[7:0])
		settle();
		chk_normal("reset pads");
		`TB_CHK("strap", modeStrapZero, coreStrap)
		$display("test reset done");
	endtask

	// control cell off first, then on: the image drives values, cell 19 the enables
	task automatic t_extest();
		load(`BST_OP_EXTEST);
		u_bst_jtag_host.scan(1'b0, 20, cells(IMG, 1'b0, 1'b0), dout, oeAll);
		settle();
		`TB_CHK("extest off oe", 18'h00000, padOe)
		u_bst_jtag_host.scan(1'b0, 20, cells(IMG, 1'b0, 1'b1), dout, oeAll);
		`TB_CHK("extest capture", cells(extPads, 1'b1, 1'b0), dout)
		settle();
		`TB_CHK("extest out", IMG, padOut)
		`TB_CHK("extest on oe", 18'h3FFFF, padOe)
		$display("test extest done");
	endtask

	task automatic t_clamp();
		load(`BST_OP_CLAMP);
		u_bst_jtag_host.scan(1'b0, 8, 20'h3C, dout, oeAll);
		`TB_CHK("clamp bypass", 8'h78, dout[7:0])
		`TB_CHK("clamp out", IMG, padOut)
		`TB_CHK("clamp oe", 18'h3FFFF, padOe)
		$display("test clamp done");
	endtask

	task automatic t_highz();
		load(`BST_OP_HIGHZ);
		`TB_CHK("highz oe", 18'h00000, padOe)
		u_bst_jtag_host.scan(1'b0, 8, 20'hC3, dout, oeAll);
		`TB_CHK("highz data out drives", 1'b1, oeAll)
		`TB_CHK("highz bypass", 8'h86, dout[7:0])
		$display("test highz done");
	endtask

	// sample must leave the core in charge; the strap drops so cell 13 shows a live level
	task automatic t_sample();
		bst_pads_t lvl;
		@(negedge sys_clk);
		modeStrapZero = 1'b0;
		load(`BST_OP_SAMPLE);
		chk_normal("sample pads");
		`TB_CHK("sample strap", 1'b0, coreStrap)
		lvl = bst_pads_t'((coreOut & coreOe) | (extPads & ~coreOe));
		u_bst_jtag_host.scan(1'b0, 20, cells(IMG, 1'b0, 1'b1), dout, oeAll);
		`TB_CHK("sample capture", cells(lvl, 1'b0, 1'b1), dout)
		settle();
		chk_normal("sample after");
		$display("test sample done");
	endtask

	// both ways back to bypass drop the extest drive
	task automatic t_back_to_bypass();
		load(`BST_OP_EXTEST);
		`TB_CHK("preload oe", 18'h3FFFF, padOe)
		u_bst_jtag_host.go_reset();
		settle();
		chk_normal("tms reset");
		load(`BST_OP_EXTEST);
		u_bst_jtag_host.set_trst(1'b0);
		#100;
		u_bst_jtag_host.set_trst(1'b1);
		settle();
		chk_normal("test reset");
		$display("test back to bypass done");
	endtask

	// hang guard
	initial begin
		repeat (40000) @(posedge sys_clk);
		fail_count++;
		$display("ERROR watchdog expected done seen hang");
		end_of_test();
	end

	initial begin
		rst_n = 1'b0;
		coreOut = 18'h2A5C3;
		coreOe = 18'h0F0F0;
		extPads = 18'h15A3C;
		modeStrapZero = 1'b1;
		repeat (10) @(negedge sys_clk);
		rst_n = 1'b1;
		u_bst_jtag_host.set_trst(1'b1);
		settle();
		t_reset();
		t_extest();
		t_clamp();
		t_highz();
		t_sample();
		t_back_to_bypass();
		end_of_test();
	end
endmodule
`default_nettype wire
